/* sbc_defines.svh */
`ifndef SBC_DEFINES_SVH
`define SBC_DEFINES_SVH

// register address codes in the header
`define ADDR_MODE 2'h0
`define ADDR_IRQ 2'h1
`define ADDR_SETUP 2'h2
`define ADDR_PHY 2'h3

// frame layout
`define FRAME_CLOCKS 5'h10
`define HDR_LAST_IDX 5'h03
`define CNT_MAX 5'h1F
`define REG_RESET 12'h000
`define SPI_FAIL_BIT 0

// operating mode codes of the mode word
`define OM_UNDEF 3'h0
`define OM_INIT_FLASH 3'h3
`define OM_INIT_NORMAL 3'h5

// timing, clock rate in MHz
`define CLK_MHZ 25
`define IRQ_RELEASE_US 2
`define IRQ_RELEASE_CYC (`IRQ_RELEASE_US * `CLK_MHZ)
`define RST_PULSE_US 20
`define RST_PULSE_CYC (`RST_PULSE_US * `CLK_MHZ)
`define IRQ_TIMEOUT_MS 256
`define IRQ_TIMEOUT_CYC (`IRQ_TIMEOUT_MS * 1000 * `CLK_MHZ)

// write stream buffer
`define FIFO_DEPTH 8
`define WORD_W 14

`endif

/* sbc_pkg.sv */
package sbc_pkg;

  // operating mode reported by the mode sequencer
  typedef enum logic [5:0] {
    MODE_STARTUP = 6'b000001,
    MODE_RESTART = 6'b000010,
    MODE_NORMAL = 6'b000100,
    MODE_STANDBY = 6'b001000,
    MODE_FLASH = 6'b010000,
    MODE_SLEEP = 6'b100000
  } chip_mode_t;

  // frame phase of the serial port
  typedef enum logic [1:0] {
    PH_IDLE = 2'b01,
    PH_SHIFT = 2'b10
  } frame_phase_t;

  // software controlled registers
  typedef struct packed {
    logic [11:0] operating_mode_control;
    logic [11:0] irq_mask_control;
    logic [11:0] special_setup_control;
    logic [11:0] system_setup_control;
    logic [11:0] bus_phy_control;
    logic [11:0] scratch_word_0;
    logic [11:0] scratch_word_1;
  } ctrl_regs_t;

  // one accepted write handed to the chip core
  typedef struct packed {
    logic [1:0] addr;
    logic [11:0] data;
  } wr_word_t;

  // pin bundle: select, clock, data
  typedef struct packed {
    logic sel_n;
    logic clk;
    logic dat;
  } pins_t;

endpackage

/* sbc_spi_register_access.sv */
// Overview of operation
// - answer only while select low; float otherwise
// - sample on falling, change on rising edge
// - full duplex: feedback out while data in
// - not 16 clocks: ignore, raise enabled failure
// - boot modes: wrong count forces system reset
// - forbidden mode transition forces system reset
// - undefined mode or period code: reset, ignore
// - frame is 4 header plus 12 data bits
// - address, feedback select, then no-write flag
// - no-write flag set: read only, no change
// - address 00: mode write, status/fault read
// - address 01 writes mask or special setup
// - address 01 readback with feedback select depends on mode
// - address 10 writes setup or scratch 0
// - address 11 writes phy or scratch 1
// - mode write serves watchdog and sets mode
// - every control bit but the mode word readable via feedback
// - interrupt low while any pending flag set
// - reading flags or system reset clears them
// - interrupt released for hold time after read
// - flags unread past timeout force reset
// - bit 13 feedback select, bit 12 no-write
`timescale 1ns/1ps
`include "sbc_defines.svh"

// small synchronous fifo for the write stream
module sbc_word_fifo #(
  parameter int WIDTH = `WORD_W,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic core_clk, // core clock
  input wire logic reset, // async reset, high
  input wire logic in_valid, // word offered
  output logic in_ready, // room for a word
  input wire logic [WIDTH-1:0] in_data, // word in
  output logic out_valid, // word available
  input wire logic out_ready, // consumer takes word
  output logic [WIDTH-1:0] out_data // oldest word
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  // whole fifo state in one record
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem; // storage
    logic [AW-1:0] wp; // write index
    logic [AW-1:0] rp; // read index
    logic [AW:0] cnt; // fill level
    logic ov; // not empty, registered
    logic [WIDTH-1:0] od; // head word, registered
  } fifo_state_t;
  fifo_state_t s; // current state
  fifo_state_t n; // next state
  logic do_wr; // write this cycle
  logic do_rd; // read this cycle
  // room from the fill level, outputs from head flops
  assign in_ready = (s.cnt != FULL);
  assign out_valid = s.ov;
  assign out_data = s.od;
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  // next state of pointers and storage
  always_comb begin
    n = s;
    if (do_wr) begin
      n.mem[s.wp] = in_data;
      n.wp = AW'(s.wp + 1'b1);
    end
    if (do_rd) begin
      n.rp = AW'(s.rp + 1'b1);
    end
    case ({do_wr, do_rd})
      2'b10: n.cnt = (AW+1)'(s.cnt + 1'b1); // fill
      2'b01: n.cnt = (AW+1)'(s.cnt - 1'b1); // drain
      default: n.cnt = s.cnt; // both or none
    endcase
    n.ov = (n.cnt != '0); // valid flop tracks fill level
    n.od = n.mem[n.rp]; // head flop tracks read index
  end
  // state register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule

// serial register port of the system basis chip
module sbc_spi_register_access #(
  parameter int unsigned IRQ_TIMEOUT_CYC = `IRQ_TIMEOUT_CYC
) (
  input wire logic core_clk, // core clock, 25 MHz
  input wire logic reset, // async reset, high
  input wire logic port_select_n, // select pin, low
  input wire logic serial_clk, // serial clock pin
  input wire logic serial_in, // serial data pin
  output logic serial_out, // serial data out
  output logic serial_out_oe, // data out driven
  output logic irq_out_n, // interrupt level, low
  output logic irq_out_n_oe, // interrupt pulled
  output logic system_reset_n, // forced reset, low
  input sbc_pkg::chip_mode_t chip_mode, // mode now
  input wire logic [11:0] status_word, // state
  input wire logic [11:0] diag_word, // faults
  input wire logic [11:0] irq_events, // event pulses
  output sbc_pkg::ctrl_regs_t ctrl, // control regs
  output logic wr_valid, // write word waiting
  input wire logic wr_ready, // core takes word
  output sbc_pkg::wr_word_t wr_word // address, data
);
  import sbc_pkg::*;

  // whole port state in one record
  typedef struct packed {
    pins_t meta; // first sync stage
    pins_t sync; // second sync stage
    pins_t prev; // delayed for edges
    frame_phase_t phase; // frame phase
    logic [4:0] count; // sampling edges seen
    logic [15:0] rx; // bits shifted in
    logic [15:0] tx; // bits shifting out
    logic out_oe; // data out enable
    ctrl_regs_t regs; // control registers
    logic [11:0] pending; // interrupt flags
    logic [11:0] release_cnt; // release hold
    logic [23:0] timeout_cnt; // unread time
    logic [11:0] rst_cnt; // reset pulse left
    logic rst_n; // reset pin level
    logic irq_oe; // interrupt pulled
    logic push; // write word to fifo
    wr_word_t push_word; // word for fifo
  } port_state_t;

  localparam logic [11:0] RELEASE_CYC = 12'(`IRQ_RELEASE_CYC);
  localparam logic [11:0] RST_CYC = 12'(`RST_PULSE_CYC);
  localparam logic [23:0] TIMEOUT_LAST = 24'(IRQ_TIMEOUT_CYC - 1);

  port_state_t s; // current state
  port_state_t n; // next state
  logic fifo_ready; // room in write fifo

  // start-up or restart: boot modes
  function automatic logic is_boot(chip_mode_t m);
    return (m == MODE_STARTUP) || (m == MODE_RESTART);
  endfunction

  // normal or standby: full register set
  function automatic logic is_run(chip_mode_t m);
    return (m == MODE_NORMAL) || (m == MODE_STANDBY);
  endfunction

  // defined watchdog period codes
  function automatic logic wdp_ok(logic [5:0] w);
    case (w)
      6'h09, 6'h0C, 6'h12, 6'h14, 6'h1B: return 1'b1;
      6'h24, 6'h2D, 6'h33, 6'h35, 6'h36: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // init codes only from boot modes
  function automatic logic move_ok(chip_mode_t m,
                                   logic [2:0] om);
    logic init;
    init = (om == `OM_INIT_NORMAL) || (om == `OM_INIT_FLASH);
    return is_boot(m) ? init : !init;
  endfunction

  // feedback word picked by the header
  function automatic logic [11:0] feedback(
    logic [1:0] addr, logic sel, chip_mode_t m,
    ctrl_regs_t r, logic [11:0] st, logic [11:0] dg,
    logic [11:0] pend);
    logic [11:0] w;
    w = `REG_RESET;
    case (addr)
      `ADDR_MODE: begin
        w = sel ? dg : st;
      end
      `ADDR_IRQ: begin
        if (!sel) begin
          w = r.irq_mask_control;
        end else if (is_boot(m)) begin
          w = r.special_setup_control;
        end else begin
          w = pend;
        end
      end
      `ADDR_SETUP: begin
        w = sel ? r.scratch_word_0 : r.system_setup_control;
      end
      `ADDR_PHY: begin
        w = sel ? r.scratch_word_1 : r.bus_phy_control;
      end
      default: w = `REG_RESET;
    endcase
    return w;
  endfunction

  // outputs straight from state flops, interrupt level tied low
  assign serial_out = s.tx[15];
  assign serial_out_oe = s.out_oe;
  assign irq_out_n = 1'b0;
  assign irq_out_n_oe = s.irq_oe;
  assign system_reset_n = s.rst_n;
  assign ctrl = s.regs;

  // next state of the whole port
  always_comb begin
    logic fall; // sampling edge
    logic rise; // shifting edge
    logic sel_fall; // frame begins
    logic sel_rise; // frame ends
    logic fail; // bad frame
    logic force_rst; // reset request
    logic clr; // flags read out
    logic [11:0] set; // new flags
    logic [3:0] hdr; // header of frame
    logic [11:0] dat; // data of frame
    n = s;
    fail = 1'b0;
    force_rst = 1'b0;
    clr = 1'b0;
    n.push = 1'b0;
    // two stages before any logic
    n.meta = '{sel_n: port_select_n, clk: serial_clk, dat: serial_in};
    n.sync = s.meta;
    n.prev = s.sync;
    fall = s.prev.clk && !s.sync.clk;
    rise = !s.prev.clk && s.sync.clk;
    sel_fall = s.prev.sel_n && !s.sync.sel_n;
    sel_rise = !s.prev.sel_n && s.sync.sel_n;
    hdr = s.rx[15:12];
    dat = s.rx[11:0];
    set = irq_events & s.regs.irq_mask_control;
    case (s.phase)
      // waiting for select
      PH_IDLE: begin
        if (sel_fall) begin
          n.phase = PH_SHIFT;
          n.count = '0;
          n.tx = 16'h0000;
          n.out_oe = 1'b1;
        end
      end
      // frame in progress
      PH_SHIFT: begin
        if (fall) begin
          n.rx = {s.rx[14:0], s.sync.dat};
          if (s.count != `CNT_MAX) begin
            n.count = 5'(s.count + 1'b1);
          end
          if (s.count == `HDR_LAST_IDX) begin
            // header complete: load reply
            n.tx = {1'b0, feedback(s.rx[2:1], s.rx[0],
                    chip_mode, s.regs, status_word,
                    diag_word, s.pending), 3'b000};
          end
        end
        if (rise) begin
          n.tx = {s.tx[14:0], 1'b0};
        end
        if (sel_rise) begin
          n.phase = PH_IDLE;
          n.out_oe = 1'b0;
          if (s.count != `FRAME_CLOCKS) begin
            fail = 1'b1;
          end else begin
            // flags read: clear at frame end
            if (hdr[3:2] == `ADDR_IRQ && hdr[1] &&
                !is_boot(chip_mode)) begin
              clr = 1'b1;
            end
            if (!hdr[0]) begin
              if (!fifo_ready) begin
                fail = 1'b1; // core not taking words
              end else begin
                n.push = 1'b1;
                n.push_word = '{addr: hdr[3:2], data: dat};
                case (hdr[3:2])
                  `ADDR_MODE: begin
                    if (dat[5:3] == `OM_UNDEF ||
                        !wdp_ok(dat[11:6])) begin
                      force_rst = 1'b1;
                      n.push = 1'b0;
                    end else if (!move_ok(chip_mode,
                                          dat[5:3])) begin
                      force_rst = 1'b1;
                      n.push = 1'b0;
                    end else begin
                      // service and mode in one word
                      n.regs.operating_mode_control = dat;
                    end
                  end
                  `ADDR_IRQ: begin
                    if (is_boot(chip_mode)) begin
                      n.regs.special_setup_control = dat;
                    end else begin
                      n.regs.irq_mask_control = dat;
                    end
                  end
                  `ADDR_SETUP: begin
                    if (is_run(chip_mode)) begin
                      n.regs.system_setup_control = dat;
                    end else begin
                      n.regs.scratch_word_0 = dat;
                    end
                  end
                  `ADDR_PHY: begin
                    if (is_run(chip_mode)) begin
                      n.regs.bus_phy_control = dat;
                    end else begin
                      n.regs.scratch_word_1 = dat;
                    end
                  end
                  default: n.push = 1'b0;
                endcase
              end
            end
          end
        end
      end
      default: begin
        n.phase = PH_IDLE;
        n.out_oe = 1'b0;
      end
    endcase
    // failed frame: reset in boot, else flag
    if (fail) begin
      if (is_boot(chip_mode)) begin
        force_rst = 1'b1;
      end else begin
        set[`SPI_FAIL_BIT] = s.regs.irq_mask_control[`SPI_FAIL_BIT];
      end
    end
    // unread flags: count toward timeout
    if (s.pending == '0 || clr) begin
      n.timeout_cnt = '0;
    end else if (s.timeout_cnt == TIMEOUT_LAST) begin
      n.timeout_cnt = '0;
      force_rst = 1'b1;
    end else begin
      n.timeout_cnt = 24'(s.timeout_cnt + 1'b1);
    end
    // forced reset pulse
    if (force_rst) begin
      n.rst_cnt = RST_CYC;
    end else if (s.rst_cnt != '0) begin
      n.rst_cnt = 12'(s.rst_cnt - 1'b1);
    end
    n.rst_n = (n.rst_cnt == '0);
    // flags: new events win over read clear
    if (n.rst_cnt != '0) begin
      n.pending = '0;
    end else begin
      n.pending = (clr ? 12'h000 : s.pending) | set;
    end
    // release hold after each read
    if (clr) begin
      n.release_cnt = RELEASE_CYC;
    end else if (s.release_cnt != '0) begin
      n.release_cnt = 12'(s.release_cnt - 1'b1);
    end
    n.irq_oe = (n.pending != '0) && (n.release_cnt == '0);
  end

  // state register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s <= '0;
      s.meta <= '{sel_n: 1'b1, clk: 1'b0, dat: 1'b0};
      s.sync <= '{sel_n: 1'b1, clk: 1'b0, dat: 1'b0};
      s.prev <= '{sel_n: 1'b1, clk: 1'b0, dat: 1'b0};
      s.phase <= PH_IDLE;
      s.rst_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // accepted writes queue toward the core
  sbc_word_fifo #(
    .WIDTH(`WORD_W),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .reset(reset),
    .in_valid(s.push),
    .in_ready(fifo_ready),
    .in_data(s.push_word),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(wr_word)
  );
endmodule

/* sbc_spi_register_access_props.sv */
`timescale 1ns/1ps
// watches the serial port from its top pins only
module sbc_spi_register_access_props (
  input wire logic core_clk, // core clock
  input wire logic reset, // async reset, high
  input wire logic port_select_n, // select pin, low
  input wire logic serial_out_oe, // data out driven
  input wire logic irq_out_n, // interrupt level
  input wire logic irq_out_n_oe, // interrupt pulled
  input wire logic system_reset_n, // forced reset, low
  input sbc_pkg::ctrl_regs_t ctrl, // control regs
  input wire logic wr_valid, // write word waiting
  input wire logic wr_ready, // consumer takes word
  input sbc_pkg::wr_word_t wr_word // address, data
);
  import sbc_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  chk_float_idle: assert property (
    port_select_n [*4] |-> !serial_out_oe)
    else $error("data out driven while deselected");
  chk_drive_sel: assert property (
    !port_select_n [*6] |-> serial_out_oe)
    else $error("data out not driven while selected");
  chk_irq_level: assert property (
    irq_out_n_oe |-> !irq_out_n)
    else $error("interrupt pin not pulled low");
  chk_irq_release: assert property (
    $fell(irq_out_n_oe) |-> !irq_out_n_oe [*8])
    else $error("interrupt released too briefly");
  chk_reset_width: assert property (
    $fell(system_reset_n) |-> !system_reset_n [*8])
    else $error("forced reset pulse too short");
  chk_ctrl_idle: assert property (
    !$stable(ctrl) |-> port_select_n)
    else $error("control changed inside a frame");
  chk_push_idle: assert property (
    $rose(wr_valid) |-> port_select_n)
    else $error("write pushed inside a frame");
  chk_reset_clear: assert property (
    !system_reset_n [*2] |-> !irq_out_n_oe)
    else $error("interrupt kept during reset");
  chk_word_hold: assert property (
    wr_valid && !wr_ready |=> wr_valid && $stable(wr_word))
    else $error("waiting write word lost");
endmodule
bind sbc_spi_register_access sbc_spi_register_access_props u_props (
  .core_clk(core_clk), .reset(reset), .port_select_n(port_select_n),
  .serial_out_oe(serial_out_oe), .irq_out_n(irq_out_n),
  .irq_out_n_oe(irq_out_n_oe), .system_reset_n(system_reset_n),
  .ctrl(ctrl), .wr_valid(wr_valid), .wr_ready(wr_ready),
  .wr_word(wr_word));

/* spi_host_model.sv */
`timescale 1ns/1ps
// host master of the serial port, mode 1
module spi_host_model (
  input wire logic core_clk, // timing base
  output logic sel_n, // select, low active
  output logic sclk, // serial clock
  output logic mosi, // data to device
  input wire logic miso, // data from device
  input wire logic miso_oe // device drives miso
);
  // idle: deselected, clock parked low
  initial begin
    sel_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  // one frame of n clocks, msb first; undriven miso reads inverted
  task automatic xfer(input int n, input logic [15:0] w,
                      output logic [15:0] r);
    int i;
    logic [15:0] sh;
    sh = w;
    r = 16'h0000;
    sel_n = 1'b0;
    mosi = sh[15];
    repeat (8) @(negedge core_clk);
    for (i = 0; i < n; i++) begin
      sclk = 1'b1;
      if (i > 0) begin
        sh = sh << 1;
        mosi = sh[15];
      end
      repeat (8) @(negedge core_clk);
      sclk = 1'b0;
      r = {r[14:0], miso_oe ? miso : ~miso};
      repeat (8) @(negedge core_clk);
    end
    sel_n = 1'b1;
    mosi = ~mosi; // released line: no stale value
    repeat (8) @(negedge core_clk);
  endtask
endmodule

/* sbc_spi_register_access_tb.sv */
`timescale 1ns/1ps
module sbc_spi_register_access_tb;
  import sbc_pkg::*;
  logic core_clk = 1'b0; // core clock
  logic reset = 1'b1; // async reset
  logic sel_n, sclk, mosi; // host pins
  logic serial_out, serial_out_oe, irq_out_n, irq_out_n_oe;
  logic system_reset_n; // forced reset
  chip_mode_t chip_mode = MODE_NORMAL; // mode from sequencer
  ctrl_regs_t ctrl; // control regs
  logic wr_valid; // word waiting
  logic wr_ready = 1'b0; // consumer pop
  logic [11:0] irq_ev = 12'h000; // event pulses from core
  wr_word_t wr_word; // popped word
  logic [15:0] rx; // reply of last frame
  int err_count = 0;
  int n_tests = 0;
  int k;
  logic [11:0] bad [3] = '{12'h268, 12'h240, 12'h008}; // illegal words
  logic [1:0] wa [4] = '{2'h0, 2'h1, 2'h2, 2'h3}; // boot addresses
  logic [11:0] wd [4] = '{12'h268, 12'h2D3, 12'h0F1, 12'h1E2};
  // core clock, 40 ns
  always #20 core_clk = ~core_clk;
  spi_host_model host (.core_clk(core_clk), .sel_n(sel_n),
    .sclk(sclk), .mosi(mosi), .miso(serial_out), .miso_oe(serial_out_oe));
  sbc_spi_register_access #(.IRQ_TIMEOUT_CYC(2000)) DUT (
    .core_clk(core_clk), .reset(reset), .port_select_n(sel_n),
    .serial_clk(sclk), .serial_in(mosi), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .irq_out_n(irq_out_n),
    .irq_out_n_oe(irq_out_n_oe), .system_reset_n(system_reset_n),
    .chip_mode(chip_mode), .status_word(12'hA51), .diag_word(12'h3C6),
    .irq_events(irq_ev), .ctrl(ctrl), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_word(wr_word));
  // counts and verdict, then stop
  task automatic close_out();
    $display("comparisons=%0d mismatches=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // compare seen against expected
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one frame with header and data, then idle gap
  task automatic xfer(input int n, input logic [3:0] hdr,
                      input logic [11:0] d);
    host.xfer(n, {hdr, d}, rx);
    repeat (16) @(negedge core_clk);
  endtask
  // read-only frame, reply header zero
  task automatic rd(input logic [3:0] hdr, input logic [11:0] exp);
    xfer(16, hdr, 12'h000);
    check(rx, {4'h0, exp});
  endtask
  // pop one word from the write stream
  task automatic pop(input logic [13:0] exp);
    int i;
    for (i = 0; i < 50 && wr_valid !== 1'b1; i++) @(negedge core_clk);
    check(wr_word, exp);
    if (i == 50) begin
      err_count++;
      close_out();
    end
    wr_ready = 1'b1;
    @(negedge core_clk);
    wr_ready = 1'b0;
    @(negedge core_clk);
  endtask
  // wait for a forced reset pulse and its end
  task automatic wait_rst(input int lim);
    int i;
    for (i = 0; i < lim && system_reset_n !== 1'b0; i++)
      @(negedge core_clk);
    check(system_reset_n, 1'b0);
    if (i == lim) close_out();
    for (i = 0; i < 600 && system_reset_n !== 1'b1; i++)
      @(negedge core_clk);
    check(system_reset_n, 1'b1);
    if (i == 600) close_out();
  endtask
  // hang guard
  initial begin
    #4000000;
    err_count++;
    close_out();
  end
  // main sequence
  initial begin
    repeat (10) @(negedge core_clk);
    reset = 1'b0;
    @(negedge core_clk);
    check({wr_valid, serial_out_oe, irq_out_n_oe, system_reset_n,
           irq_out_n}, 5'h02);
    check(16'(ctrl !== '0), 16'h0000);
    $display("test reset done");
    chip_mode = MODE_RESTART;
    xfer(17, 4'h8, 12'h777);
    check(wr_valid, 1'b0);
    wait_rst(600);
    chip_mode = MODE_NORMAL;
    foreach (bad[j]) begin
      xfer(16, 4'h0, bad[j]);
      check(wr_valid, 1'b0);
      wait_rst(600);
    end
    $display("test refusals done");
    chip_mode = MODE_STARTUP;
    foreach (wa[j]) begin
      xfer(16, {wa[j], 2'b00}, wd[j]);
      pop({wa[j], wd[j]});
    end
    check(ctrl.operating_mode_control, 12'h268);
    check(ctrl.special_setup_control, 12'h2D3);
    check(ctrl.scratch_word_0, 12'h0F1);
    check(ctrl.scratch_word_1, 12'h1E2);
    rd(4'h7, 12'h2D3);
    rd(4'hB, 12'h0F1);
    rd(4'hF, 12'h1E2);
    $display("test boot mode done");
    chip_mode = MODE_NORMAL;
    xfer(16, 4'h8, 12'hA5C);
    pop({2'h2, 12'hA5C});
    check(ctrl.system_setup_control, 12'hA5C);
    xfer(16, 4'hC, 12'h5A3);
    pop({2'h3, 12'h5A3});
    check(ctrl.bus_phy_control, 12'h5A3);
    xfer(16, 4'h9, 12'h123);
    check(rx, 16'h0A5C);
    check(ctrl.system_setup_control, 12'hA5C);
    check(wr_valid, 1'b0);
    rd(4'hD, 12'h5A3);
    rd(4'h1, 12'hA51);
    rd(4'h3, 12'h3C6);
    chip_mode = MODE_FLASH;
    xfer(16, 4'h8, 12'h3C3);
    pop({2'h2, 12'h3C3});
    check(ctrl.scratch_word_0, 12'h3C3);
    check(ctrl.system_setup_control, 12'hA5C);
    chip_mode = MODE_NORMAL;
    $display("test normal mode done");
    xfer(16, 4'h4, 12'h001);
    pop({2'h1, 12'h001});
    xfer(15, 4'h8, 12'hFFF);
    check(ctrl.system_setup_control, 12'hA5C);
    check(irq_out_n_oe, 1'b1);
    rd(4'h5, 12'h001);
    rd(4'h7, 12'h001);
    check(irq_out_n_oe, 1'b0);
    irq_ev = 12'h001;
    @(negedge core_clk);
    irq_ev = 12'h000;
    @(negedge core_clk);
    check(irq_out_n_oe, 1'b0);
    repeat (40) @(negedge core_clk);
    check(irq_out_n_oe, 1'b1);
    rd(4'h7, 12'h001);
    check(irq_out_n_oe, 1'b0);
    $display("test interrupt done");
    for (k = 0; k < 8; k++) xfer(16, 4'h8, 12'h100 + 12'(k));
    xfer(16, 4'h8, 12'hBEE);
    check(ctrl.system_setup_control, 12'h107);
    check(irq_out_n_oe, 1'b1);
    for (k = 0; k < 8; k++) pop({2'h2, 12'h100 + 12'(k)});
    @(negedge core_clk);
    check(wr_valid, 1'b0);
    wait_rst(2100);
    $display("test buffer and timeout done");
    close_out();
  end
endmodule
